//--- src/adcrc_top.sv
`default_nettype none

module adcrc_top (
    // Clock and reset.
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    // AXI4-Lite write address and data.
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [adcrc_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    // AXI4-Lite write response.
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    output logic [1:0] S_AXI_BRESP_O,
    // AXI4-Lite read.
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    input wire logic [adcrc_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    // Oscillator mode strap: 1 for internal or external RC, 0 for crystal.
    input wire logic RC_OSC_MODE_I,
    // Analog converter side.
    input wire logic COMPARATOR_I,
    output logic SAMPLE_HOLD_O,
    output logic [adcrc_pkg::RES_W-1:0] TRIAL_CODE_O,
    output logic CONVERTER_POWER_O,
    output logic [2:0] CHANNEL_SELECT_O,
    output logic INPUT_SEVEN_PIN_SWITCH_O,
    output logic INPUT_EIGHT_PIN_SWITCH_O,
    output logic [7:0] PORT_C_SWITCH_O,
    // Interrupt.
    output logic IRQ_O
);
    import adcrc_pkg::*;

    // Every flip-flop of this module outside the sequencer lives in this record.
    // One always_comb builds the next copy, one always_ff registers it.
    typedef struct packed {
        // Bus slave.
        logic awready;
        logic wready;
        // Write halves taken but not yet applied.
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] waddr;
        logic [7:0] wbyte;
        logic wlane;
        // Write response.
        logic bvalid;
        logic [1:0] bresp;
        // Read channel.
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;

        // Registers.
        logic pin_seven;
        logic pin_eight;
        logic start;
        logic power;
        logic [1:0] clk_div;
        logic [2:0] chan;
        logic [7:0] port_c;
        // Interrupt mask and sticky status.
        logic [7:0] irq_mask;
        logic [7:0] irq_status;
        // Latest result, both halves.
        logic [RES_W-1:0] result;

        // Converter clock divider and outputs.
        logic [DIV_W-1:0] div_cnt;
        logic tick;
        logic sample;
        logic [RES_W-1:0] trial;
        // Registered interrupt level.
        logic irq;
    } adcrc_state_t;

    adcrc_state_t s_r;
    adcrc_state_t s_nxt;

    // Sequencer outputs are registered once more before reaching a pin.
    // That costs a cycle of latency but keeps every output on a flip-flop.
    logic sar_sample;
    logic [RES_W-1:0] sar_trial;
    logic sar_done;
    logic [RES_W-1:0] sar_result;

    // Converter clock period in system clocks, minus one.
    // The crystal divisor rounds down, so its rates sit a bit high.
    function automatic logic [DIV_W-1:0] div_limit(input logic rc_mode, input logic [1:0] sel);
        logic [DIV_W-1:0] base;
        base = rc_mode ? RC_PRE_DIV : XTAL_BASE_DIV;
        // Cannot wrap: the smallest base is four.
        return (base << sel) - DIV_W'(1);
    endfunction : div_limit

    // Known address check shared by the read and write paths.
    // Unmapped addresses answer SLVERR and change nothing.
    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        return (a == ADDR_PIN_SWITCH) || (a == ADDR_CONTROL) || (a == ADDR_PORT_C) ||
               (a == ADDR_IRQ_MASK) || (a == ADDR_IRQ_STATUS) ||
               (a == ADDR_RESULT_LO) || (a == ADDR_RESULT_HI);
    endfunction : addr_known

    // Read data for one register; bits above the byte read as zero.
    // Control bit 1 is not stored, so it always reads as zero.
    function automatic logic [31:0] reg_read(input adcrc_state_t s, input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        v = '0;
        // Unmapped addresses fall to the default.
        unique case (a)
            ADDR_PIN_SWITCH: begin
                v[PIN_SEVEN_BIT] = s.pin_seven;
                v[PIN_EIGHT_BIT] = s.pin_eight;
            end
            ADDR_CONTROL: begin
                v[CTRL_START_BIT] = s.start;
                v[CTRL_POWER_BIT] = s.power;
                v[CTRL_DIV_LSB +: 2] = s.clk_div;
                v[CTRL_CHAN_LSB +: 3] = s.chan;
            end
            ADDR_PORT_C: v = s.port_c;
            ADDR_IRQ_MASK: v = s.irq_mask;
            ADDR_IRQ_STATUS: v = s.irq_status;
            // Result split: low eight bits, then the top two.
            ADDR_RESULT_LO: v = s.result[7:0];
            ADDR_RESULT_HI: v[RES_HI_LSB +: 2] = s.result[RES_W-1:8];
            default: v = '0;
        endcase
        return {24'h000000, v};
    endfunction : reg_read

    // Conversion sequencer; it runs only while powered and started.
    // Dropping power or start aborts a conversion in flight without a flag.
    adcrc_sar u_sar (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .tick_i(s_r.tick),
        .run_i(s_r.start & s_r.power),
        .cmp_i(COMPARATOR_I),
        .sample_o(sar_sample),
        .trial_o(sar_trial),
        .done_o(sar_done),
        .result_o(sar_result)
    );

    // Next-state logic for bus, registers, divider and interrupt.
    always_comb begin
        logic do_write;
        logic do_read;
        logic hw_clear_start;
        logic set_done;
        logic [7:0] status_next;
        // Every local gets a value before any branch reads it.
        do_write = 1'b0;
        do_read = 1'b0;
        hw_clear_start = 1'b0;
        set_done = 1'b0;
        status_next = s_r.irq_status;
        s_nxt = s_r;

        // Converter clock divider restarts whenever the converter is idle,
        // so the first sample period after a start is always a full tick.
        s_nxt.tick = 1'b0;
        // Idle: hold the counter at zero.
        if (!(s_r.start && s_r.power)) begin
            s_nxt.div_cnt = '0;
        end else if (s_r.div_cnt >= div_limit(RC_OSC_MODE_I, s_r.clk_div)) begin
            s_nxt.div_cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + DIV_W'(1);
        end

        // Pin-facing copies of the sequencer.
        s_nxt.sample = sar_sample;
        s_nxt.trial = sar_trial;

        // Completion: flag and stop only when unmasked, else keep converting.
        // The result still updates on every pass, so software may poll it.
        hw_clear_start = 1'b0;
        set_done = 1'b0;
        if (sar_done) begin
            s_nxt.result = sar_result;
            if (s_r.irq_mask[IRQ_DONE_BIT]) begin
                hw_clear_start = 1'b1;
                set_done = 1'b1;
            end
        end

        if (hw_clear_start) begin
            s_nxt.start = 1'b0;
        end

        // Write address and data are taken independently, in either order.
        // Each ready stays low until the response handshake.
        // Address half.
        if (s_r.awready && S_AXI_AWVALID_I) begin
            s_nxt.awready = 1'b0;
            s_nxt.aw_got = 1'b1;
            s_nxt.waddr = S_AXI_AWADDR_I;
        end

        // Data half.
        if (s_r.wready && S_AXI_WVALID_I) begin
            s_nxt.wready = 1'b0;
            s_nxt.w_got = 1'b1;
            s_nxt.wbyte = S_AXI_WDATA_I[7:0];
            s_nxt.wlane = S_AXI_WSTRB_I[0];
        end

        // Apply the write once both halves are held; only byte lane 0 carries data.
        do_write = s_r.aw_got && s_r.w_got && !s_r.bvalid;
        if (do_write) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = addr_known(s_r.waddr) ? RESP_OKAY : RESP_SLVERR;
            // A cleared lane strobe leaves the registers alone.
            if (s_r.wlane) begin
                unique case (s_r.waddr)
                    ADDR_PIN_SWITCH: begin
                        s_nxt.pin_seven = s_r.wbyte[PIN_SEVEN_BIT];
                        s_nxt.pin_eight = s_r.wbyte[PIN_EIGHT_BIT];
                    end
                    ADDR_CONTROL: begin
                        // The written value wins over a same-cycle hardware clear.
                        s_nxt.start = s_r.wbyte[CTRL_START_BIT];
                        s_nxt.power = s_r.wbyte[CTRL_POWER_BIT];
                        s_nxt.clk_div = s_r.wbyte[CTRL_DIV_LSB +: 2];
                        s_nxt.chan = s_r.wbyte[CTRL_CHAN_LSB +: 3];
                    end
                    // Port C bit 0 is only stored; keeping it set is up to software.
                    ADDR_PORT_C: s_nxt.port_c = s_r.wbyte;
                    ADDR_IRQ_MASK: s_nxt.irq_mask = s_r.wbyte & IRQ_MASK_USED;
                    // Status and result are read-only.
                    default: begin
                    end
                endcase
            end
        end
        // Response handshake reopens both write halves.
        if (s_r.bvalid && S_AXI_BREADY_I) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready = 1'b1;
        end

        // Read: one cycle after the address is taken the data is offered.
        // A status read clears the register as it is taken.
        do_read = s_r.arready && S_AXI_ARVALID_I;
        status_next = s_r.irq_status;
        if (do_read) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = reg_read(s_r, S_AXI_ARADDR_I);
            s_nxt.rresp = addr_known(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
            // Clear on read.
            if (S_AXI_ARADDR_I == ADDR_IRQ_STATUS) begin
                status_next = '0;
            end
        end
        // Read handshake reopens the address channel.
        if (s_r.rvalid && S_AXI_RREADY_I) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end

        // The hardware set is applied last so it is never lost to a read clear.
        // The interrupt uses the next mask and status so all three move together.
        if (set_done) begin
            status_next[IRQ_DONE_BIT] = 1'b1;
        end
        s_nxt.irq_status = status_next;
        s_nxt.irq = |(status_next & s_nxt.irq_mask);
    end

    // State register with synchronous reset.
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            s_r <= '0;
            // Ready outputs idle high so a master may start at once.
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
            s_r.port_c <= REG_RESET;
            s_r.irq_mask <= REG_RESET;
            s_r.irq_status <= REG_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign S_AXI_AWREADY_O = s_r.awready;
    assign S_AXI_WREADY_O = s_r.wready;
    assign S_AXI_BVALID_O = s_r.bvalid;
    assign S_AXI_BRESP_O = s_r.bresp;

    assign S_AXI_ARREADY_O = s_r.arready;
    assign S_AXI_RVALID_O = s_r.rvalid;
    assign S_AXI_RDATA_O = s_r.rdata;
    assign S_AXI_RRESP_O = s_r.rresp;

    // Converter and pin outputs.
    assign SAMPLE_HOLD_O = s_r.sample;
    assign TRIAL_CODE_O = s_r.trial;
    assign CONVERTER_POWER_O = s_r.power;
    assign CHANNEL_SELECT_O = s_r.chan;
    assign INPUT_SEVEN_PIN_SWITCH_O = s_r.pin_seven;
    assign INPUT_EIGHT_PIN_SWITCH_O = s_r.pin_eight;
    assign PORT_C_SWITCH_O = s_r.port_c;

    // Interrupt level.
    assign IRQ_O = s_r.irq;

endmodule : adcrc_top

`default_nettype wire

//--- src/adcrc_pkg.sv
`default_nettype none

package adcrc_pkg;

    // System clock and converter timing.
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned XTAL_MAX_RATE_HZ = 74600;
    localparam int unsigned CONV_CYCLES = 12;
    localparam int unsigned RC_PRE_DIV_N = 4;
    localparam int unsigned DIV_W = 12;
    localparam logic [DIV_W-1:0] RC_PRE_DIV = DIV_W'(RC_PRE_DIV_N);
    localparam logic [DIV_W-1:0] XTAL_BASE_DIV =
        DIV_W'(CLK_HZ / (XTAL_MAX_RATE_HZ * CONV_CYCLES));

    // Converter result layout.
    localparam int unsigned RES_W = 10;
    localparam int unsigned STEP_W = 4;
    localparam logic [RES_W-1:0] TRIAL_MID = 10'h200;
    localparam logic [STEP_W-1:0] LAST_BIT_STEP = 4'(RES_W);

    // Register byte addresses.
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_PIN_SWITCH = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_PORT_C = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_LO = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_HI = 8'h18;

    // Field positions.
    localparam int unsigned PIN_SEVEN_BIT = 0;
    localparam int unsigned PIN_EIGHT_BIT = 1;
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_POWER_BIT = 2;
    localparam int unsigned CTRL_DIV_LSB = 3;
    localparam int unsigned CTRL_CHAN_LSB = 5;
    localparam int unsigned IRQ_DONE_BIT = 5;
    localparam int unsigned RES_HI_LSB = 4;
    localparam logic [7:0] IRQ_MASK_USED = 8'hb0;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Converter sequence phases.
    typedef enum logic [2:0] {
        ADCRC_IDLE = 3'b001,
        ADCRC_SAMPLE = 3'b010,
        ADCRC_CONVERT = 3'b100
    } adcrc_phase_t;

endpackage : adcrc_pkg

`default_nettype wire

//--- src/adcrc_sar.sv
`default_nettype none

// Successive-approximation sequencer: one sample tick, ten bit ticks, one finish tick.
module adcrc_sar (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control.
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic cmp_i,
    // Analog side and result.
    output logic sample_o,
    output logic [adcrc_pkg::RES_W-1:0] trial_o,
    output logic done_o,
    output logic [adcrc_pkg::RES_W-1:0] result_o
);
    import adcrc_pkg::*;

    typedef struct packed {
        adcrc_phase_t phase;
        logic [STEP_W-1:0] step;
        logic sample;
        logic [RES_W-1:0] trial;
        logic done;
        logic [RES_W-1:0] result;
    } adcrc_sar_t;

    adcrc_sar_t s_r;
    adcrc_sar_t s_nxt;

    // Sequence steps advance only on converter clock ticks.
    always_comb begin
        logic [STEP_W-1:0] bit_idx;
        bit_idx = '0;
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (!run_i) begin
            // Dropping run aborts a conversion half way; nothing is reported.
            s_nxt.phase = ADCRC_IDLE;
            s_nxt.step = '0;
            s_nxt.sample = 1'b0;
            s_nxt.trial = '0;
        end else if (tick_i) begin
            unique case (s_r.phase)
                ADCRC_IDLE: begin
                    s_nxt.phase = ADCRC_SAMPLE;
                    s_nxt.sample = 1'b1;
                    s_nxt.trial = TRIAL_MID;
                    s_nxt.step = '0;
                end
                ADCRC_SAMPLE: begin
                    s_nxt.phase = ADCRC_CONVERT;
                    s_nxt.sample = 1'b0;
                    s_nxt.step = 4'h1;
                end
                ADCRC_CONVERT: begin
                    if (s_r.step <= LAST_BIT_STEP) begin
                        // One shared sample path resolves ten bits, MSB first.
                        bit_idx = LAST_BIT_STEP - s_r.step;
                        if (!cmp_i) begin
                            s_nxt.trial[bit_idx] = 1'b0;
                        end
                        if (bit_idx != '0) begin
                            s_nxt.trial[bit_idx - 4'h1] = 1'b1;
                        end
                        s_nxt.step = s_r.step + 4'h1;
                    end else begin
                        // Twelfth tick publishes the result.
                        s_nxt.result = s_r.trial;
                        s_nxt.done = 1'b1;
                        s_nxt.phase = ADCRC_IDLE;
                        s_nxt.step = '0;
                    end
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_r <= '{phase: ADCRC_IDLE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sample_o = s_r.sample;
    assign trial_o = s_r.trial;
    assign done_o = s_r.done;
    assign result_o = s_r.result;

endmodule : adcrc_sar

`default_nettype wire

//--- sim/adcrc_checker_sva.sv
`default_nettype none

// Watches the register bus, the converter pins and the interrupt of the control block.
module adcrc_checker
    import adcrc_pkg::*;
(
    // Clock and reset.
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    // Register bus.
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic [31:0] S_AXI_RDATA_O,
    // Converter side and interrupt.
    input wire logic SAMPLE_HOLD_O,
    input wire logic CONVERTER_POWER_O,
    input wire logic [2:0] CHANNEL_SELECT_O,
    input wire logic INPUT_SEVEN_PIN_SWITCH_O,
    input wire logic INPUT_EIGHT_PIN_SWITCH_O,
    input wire logic IRQ_O
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    // Bus steps that the properties below start from.
    sequence sq_wr_taken;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    endsequence
    sequence sq_rd_taken;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    endsequence
    sequence sq_mask_off;
        sq_wr_taken and (S_AXI_AWADDR_I == ADDR_IRQ_MASK && !S_AXI_WDATA_I[IRQ_DONE_BIT]);
    endsequence
    sequence sq_status_rd;
        sq_rd_taken and (S_AXI_ARADDR_I == ADDR_IRQ_STATUS);
    endsequence

    bvalid_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
        S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
    rvalid_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
        S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read data dropped");
    read_answer_a: assert property (sq_rd_taken |=> S_AXI_RVALID_O)
        else $error("read answer late");
    write_answer_a: assert property (sq_wr_taken |-> ##2 S_AXI_BVALID_O)
        else $error("write answer late");
    pin_seven_a: assert property ($changed(INPUT_SEVEN_PIN_SWITCH_O) |-> $rose(S_AXI_BVALID_O))
        else $error("pin seven switch moved without a write");
    pin_eight_a: assert property ($changed(INPUT_EIGHT_PIN_SWITCH_O) |-> $rose(S_AXI_BVALID_O))
        else $error("pin eight switch moved without a write");
    chan_power_a: assert property ($changed({CHANNEL_SELECT_O, CONVERTER_POWER_O}) |->
        $rose(S_AXI_BVALID_O)) else $error("channel or power moved without a write");
    power_off_a: assert property ((!CONVERTER_POWER_O) [*3] |->
        !SAMPLE_HOLD_O && !$rose(IRQ_O)) else $error("converter active while unpowered");
    irq_mask_a: assert property (sq_mask_off |-> ##[1:4] !IRQ_O)
        else $error("masked completion still interrupts");
    irq_clear_a: assert property (sq_status_rd |-> ##[1:3] !IRQ_O)
        else $error("status read did not clear interrupt");
endmodule : adcrc_checker

bind adcrc_top adcrc_checker adcrc_checker_i (.*);

`default_nettype wire

//--- sim/adcrc_analog_model.sv
`default_nettype none

// Eight analog inputs behind one shared sample-and-hold and a comparator.
module adcrc_analog_model (
    // Converter side.
    input wire logic clk_i,
    input wire logic power_i,
    input wire logic sample_i,
    input wire logic [2:0] chan_i,
    input wire logic sel7_i,
    input wire logic sel8_i,
    input wire logic [9:0] trial_i,
    input wire logic [9:0] level_i [8],
    // Comparison result.
    output logic cmp_o
);
    logic [9:0] pick;
    logic [9:0] held;
    logic junk = 1'b0;

    // A pin left on its port function feeds a wrong level, never the real one.
    always_comb begin
        pick = level_i[chan_i];
        if ((chan_i == 3'd6 && !sel7_i) || (chan_i == 3'd7 && !sel8_i)) begin
            pick = ~level_i[chan_i];
        end
    end

    // One hold stage serves all inputs, so the level freezes when sampling ends.
    always @(posedge clk_i) begin
        junk <= ~junk;
        if (sample_i) begin
            held <= pick;
        end
    end

    // Unpowered, the comparator output means nothing and keeps toggling.
    assign cmp_o = power_i ? (held >= trial_i) : junk;
endmodule : adcrc_analog_model

`default_nettype wire

//--- sim/adcrc_bench.sv
`default_nettype none

module adcrc_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import adcrc_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, rc = 1'b1;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, cmp, sample, power, sel7, sel8, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [9:0] trial;
    logic [2:0] chan;
    logic [7:0] portc;
    logic [9:0] lvl [8] = '{default: 10'h0};
    logic [33:0] rd_q [$];
    logic [1:0] wr_q [$];
    logic smp_d = 1'b0, irq_d = 1'b0;
    int mismatches = 0, checked = 0, cycles = 0, span = 0, span_irq = 0, hi_len = 0;

    adcrc_top adcrc_top_i (.REF_CLK_I(clk), .RESET_N_I(rst_n),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awready), .S_AXI_AWADDR_I(awa),
        .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(4'hf), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bry),
        .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arready),
        .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rry),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .RC_OSC_MODE_I(rc),
        .COMPARATOR_I(cmp), .SAMPLE_HOLD_O(sample), .TRIAL_CODE_O(trial),
        .CONVERTER_POWER_O(power), .CHANNEL_SELECT_O(chan), .INPUT_SEVEN_PIN_SWITCH_O(sel7),
        .INPUT_EIGHT_PIN_SWITCH_O(sel8), .PORT_C_SWITCH_O(portc), .IRQ_O(irq));

    adcrc_analog_model adcrc_analog_model_i (.clk_i(clk), .power_i(power),
        .sample_i(sample), .chan_i(chan), .sel7_i(sel7), .sel8_i(sel8), .trial_i(trial),
        .level_i(lvl), .cmp_o(cmp));

    // Free-running system clock.
    initial forever #4 clk = ~clk;

    task automatic print_verdict;
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    task automatic fail(input string m);
        mismatches++;
        $display("ERROR %0t %s", $time, m);
    endtask : fail

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail("output differs");
        end
    endtask : chk

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] r = RESP_OKAY);
        @(posedge clk);
        rd_q.push_back({r, e});
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rry <= 1'b0;
    endtask : axi_rd

    // Address and data go out together; each is dropped once its own ready is seen.
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                          input logic [1:0] r = RESP_OKAY);
        logic aw_ok, w_ok;
        @(posedge clk);
        wr_q.push_back(r);
        {awv, wv, bry} <= 3'b111;
        awa <= a;
        wdata <= {24'h0, d};
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            aw_ok |= (awready === 1'b1);
            w_ok |= (wready === 1'b1);
            awv <= !aw_ok;
            wv <= !w_ok;
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bry <= 1'b0;
    endtask : axi_wr

    // One single-shot conversion, its timing and its split result.
    task automatic conv(input logic [2:0] ch, input logic [1:0] dv, input logic rcm);
        int t;
        t = rcm ? (RC_PRE_DIV_N << dv) : (int'(XTAL_BASE_DIV) << dv);
        lvl[ch] = 10'($urandom);
        rc <= rcm;
        axi_wr(ADDR_CONTROL, {ch, dv, 3'b101});
        do @(posedge clk); while (irq !== 1'b1);
        @(negedge clk);
        chk({power, chan}, {1'b1, ch});
        checked++;
        if (hi_len < t - 1 || hi_len > t + 1 || span_irq < 12 * t || span_irq > 12 * t + 2) begin
            fail("conversion timing");
        end
        axi_rd(ADDR_IRQ_STATUS, 32'h20);
        axi_rd(ADDR_RESULT_LO, {24'h0, lvl[ch][7:0]});
        axi_rd(ADDR_RESULT_HI, {26'h0, lvl[ch][9:8], 4'h0});
        axi_rd(ADDR_CONTROL, {24'h0, ch, dv, 3'b100});
        @(negedge clk);
        chk(irq, 1'b0);
    endtask : conv

    // Results are compared with the oldest note as they appear on the bus.
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rry) begin
            checked++;
            if ({rresp, rdata} !== rd_q.pop_front()) begin
                fail("read differs");
            end
        end
        if (bvalid === 1'b1 && bry) begin
            checked++;
            if (bresp !== wr_q.pop_front()) begin
                fail("write response differs");
            end
        end
    end

    // Sample width and sample-to-interrupt span, plus the hang limit.
    always @(posedge clk) begin
        if (sample === 1'b1 && smp_d !== 1'b1) begin
            span = 0;
            hi_len = 0;
        end
        hi_len += int'(sample === 1'b1);
        span++;
        if (irq === 1'b1 && irq_d !== 1'b1) begin
            span_irq = span;
        end
        smp_d = sample;
        irq_d = irq;
        cycles++;
        if (cycles == 60000) begin
            fail("timeout");
            print_verdict();
        end
    end

    initial begin
        void'($urandom(32'h85de));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8'h1c; a += 4) begin
            axi_rd(8'(a), 32'h0);
        end
        axi_rd(8'h1c, 32'h0, RESP_SLVERR);
        axi_wr(8'h20, 8'hff, RESP_SLVERR);
        // Pins are handed to the converter before any channel uses them.
        for (int p = 1; p < 4; p++) begin
            axi_wr(ADDR_PIN_SWITCH, 8'(p));
            @(negedge clk);
            chk({sel8, sel7}, p);
            axi_rd(ADDR_PIN_SWITCH, p);
        end
        axi_wr(ADDR_PORT_C, 8'h01);
        @(negedge clk);
        chk(portc, 32'h1);
        axi_rd(ADDR_PORT_C, 32'h1);
        axi_wr(ADDR_IRQ_MASK, 8'hff);
        axi_rd(ADDR_IRQ_MASK, 32'hb0);
        axi_wr(ADDR_IRQ_MASK, 8'h20);
        for (int c = 0; c < 8; c++) begin
            conv(3'(c), 2'd0, 1'b1);
        end
        for (int d = 1; d < 4; d++) begin
            conv(3'd5, 2'(d), 1'b1);
        end
        conv(3'd2, 2'd0, 1'b0);
        conv(3'd7, 2'd1, 1'b0);
        // With completion masked the converter keeps running and start stays set.
        axi_wr(ADDR_IRQ_MASK, 8'h00);
        axi_wr(ADDR_CONTROL, 8'h25);
        repeat (3500) @(posedge clk);
        axi_rd(ADDR_IRQ_STATUS, 32'h0);
        axi_rd(ADDR_CONTROL, 32'h25);
        axi_wr(ADDR_IRQ_MASK, 8'h20);
        do @(posedge clk); while (irq !== 1'b1);
        axi_rd(ADDR_CONTROL, 32'h24);
        axi_rd(ADDR_IRQ_STATUS, 32'h20);
        // A start without power must stay silent.
        axi_wr(ADDR_CONTROL, 8'h01);
        repeat (200) @(posedge clk);
        @(negedge clk);
        chk(irq, 1'b0);
        axi_rd(ADDR_IRQ_STATUS, 32'h0);
        print_verdict();
    end
endmodule : adcrc_bench

`default_nettype wire
